// ===== rtl/nibble_port_defines.svh
`ifndef NIBBLE_PORT_DEFINES_SVH
`define NIBBLE_PORT_DEFINES_SVH
// ==========================================
// Register byte offsets
`define OFS_IN_DATA   8'h00
`define OFS_IN_PULL   8'h04
`define OFS_OUT_LATCH 8'h08
`define OFS_OUT_SET   8'h0C
`define OFS_OUT_CLR   8'h10
`define OFS_DIR       8'h14
`define OFS_PULL_GRP  8'h18
`define OFS_PIN_DATA  8'h1C
`define OFS_OD_SEL    8'h20
`define OFS_ALT_EN    8'h24
`define OFS_EDGE_SEL  8'h28
`define OFS_TONE_CTL  8'h2C
`define OFS_IRQ_STAT  8'h30
`define OFS_IRQ_MASK  8'h34
// ==========================================
// Field positions
`define IRQ_EDGE_A    0
`define IRQ_EDGE_B    1
`define IRQ_RISE_Q    2
`define IRQ_BOTH      3
`define IRQ_KEY       4
`define ALT_TIMER0    0
`define ALT_TIMER1    1
`define ALT_DIVCLK    2
`define ALT_TONE      3
`define ALT_INTERVAL  4
`define TONE_EN_BIT   2
`define OD_LSB        8
`define KEY_LSB       16
`define TMR0_IN_BIT   4
`define TMR1_IN_BIT   5
`define INTERVAL_PIN  8
// ==========================================
// Reset values and timing
`define RST_WORD      32'h0000_0000
`define SYS_CLK_HZ    200000000
`define TONE_MAX_HZ   16000
`endif

// ===== rtl/nibble_port_pins.sv
`timescale 1ns/1ps
// Function
// - Four-bit input-only port, readable as a bit or nibble.
// - Each input-only bit has its own software pull-up enable.
// - Each bidirectional pin has its own direction; bit and nibble access.
// - Port pull-ups set per nibble, forced off on output pins.
// - Ports 4 and 5 pick open-drain or push-pull per bit.
// - Port pairs 2/3, 4/5, 6/7, 8/9 move as one byte.
// - First two edge interrupts trigger on a software chosen edge.
// - Third interrupt input requests on every rising edge.
// - Fourth interrupt input requests on both edges.
// - Any falling edge on the eight key-scan inputs raises a request.
// - Tone pin outputs 2, 4, 8 or 16 kHz square waves.
`include "nibble_port_defines.svh"
module nibble_port_pins #(
   parameter int TONE_HALF_16K = `SYS_CLK_HZ / (2 * `TONE_MAX_HZ)
)(
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire nibble_port_pkg::addr_t avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire nibble_port_pkg::word_t avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output nibble_port_pkg::word_t     avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [3:0]            inputOnlyPortBit,
   output logic [3:0]                 inputPullUpEn,
   input  wire logic [31:0]           ioPinIn,
   output logic [31:0]                ioPinOut,
   output logic [31:0]                ioPinOe,
   output logic [31:0]                ioPullUpEn,
   input  wire logic                  timer0ClkPinSrc,
   input  wire logic                  timer1ClkPinSrc,
   input  wire logic                  dividedSysclkPinSrc,
   input  wire logic                  intervalTimerClkPinSrc,
   output logic                       timer0ExtClkIn,
   output logic                       timer1ExtClkIn,
   output logic                       irq
);
   import nibble_port_pkg::*;

   bus_state_t busState_q;
   logic       waitReq_q;
   word_t      rdData_q;
   word_t      rdMux;
   logic       wrEn;
   logic       takeRead;
   logic [3:0] inLevel;
   logic [3:0] inRise;
   logic [3:0] inFall;
   logic [31:0] ioLevel;
   logic [31:0] ioFall;
   logic [3:0]  inPull_q;
   logic [31:0] out_q;
   logic [31:0] dir_q;
   logic [7:0]  pullGrp_q;
   logic [7:0]  odSel_q;
   logic [4:0]  altEn_q;
   logic [1:0]  edgeSel_q;
   logic [2:0]  toneCtl_q;
   irq_vec_t    status_q;
   irq_vec_t    mask_q;
   irq_vec_t    events;
   logic        irq_q;
   logic        toneOut;
   logic [31:0] drvVal;
   logic [31:0] odFull;
   logic [31:0] pullFull;
   logic [31:0] pinOut_q;
   logic [31:0] pinOe_q;
   logic [31:0] pinPull_q;
   logic [3:0]  inPullOut_q;

   function automatic word_t beMerge(word_t old, word_t nw, logic [3:0] be);
      word_t res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================
   // Pin synchronisers and edge detectors
   pin_sync_edge #(.WIDTH(4)) u_in_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .pinRaw   (inputOnlyPortBit),
      .pinLevel (inLevel),
      .pinRise  (inRise),
      .pinFall  (inFall)
   );

   pin_sync_edge #(.WIDTH(32)) u_io_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .pinRaw   (ioPinIn),
      .pinLevel (ioLevel),
      .pinRise  (),
      .pinFall  (ioFall)
   );

   tone_gen #(.HALF_16K(TONE_HALF_16K)) u_tone (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .toneEn  (toneCtl_q[`TONE_EN_BIT]),
      .toneSel (toneCtl_q[1:0]),
      .toneOut (toneOut)
   );

   // ==========================================
   // Avalon slave: one wait cycle, then answer
   assign takeRead = (busState_q == BUS_WAIT) && avs_read;
   assign wrEn     = (busState_q == BUS_ACK) && avs_write;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         busState_q <= BUS_WAIT;
         waitReq_q  <= 1'b1;
      end
      else
      begin
         case (busState_q)
            BUS_WAIT:
            begin
               if (avs_read || avs_write)
               begin
                  busState_q <= BUS_ACK;
                  waitReq_q  <= 1'b0;
               end
            end
            BUS_ACK:
            begin
               busState_q <= BUS_WAIT;
               waitReq_q  <= 1'b1;
            end
            default:
            begin
               busState_q <= BUS_WAIT;
               waitReq_q  <= 1'b1;
            end
         endcase
      end
   end

   always_comb
   begin
      case (avs_address)
         `OFS_IN_DATA:   rdMux = {28'h000_0000, inLevel};
         `OFS_IN_PULL:   rdMux = {28'h000_0000, inPull_q};
         `OFS_OUT_LATCH: rdMux = out_q;
         `OFS_DIR:       rdMux = dir_q;
         `OFS_PULL_GRP:  rdMux = {24'h00_0000, pullGrp_q};
         `OFS_PIN_DATA:  rdMux = ioLevel;
         `OFS_OD_SEL:    rdMux = {24'h00_0000, odSel_q};
         `OFS_ALT_EN:    rdMux = {27'h000_0000, altEn_q};
         `OFS_EDGE_SEL:  rdMux = {30'h0000_0000, edgeSel_q};
         `OFS_TONE_CTL:  rdMux = {29'h0000_0000, toneCtl_q};
         `OFS_IRQ_STAT:  rdMux = {27'h000_0000, status_q};
         `OFS_IRQ_MASK:  rdMux = {27'h000_0000, mask_q};
         default:        rdMux = `RST_WORD;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rdData_q <= `RST_WORD;
      end
      else if (takeRead)
      begin
         rdData_q <= rdMux;
      end
   end

   // ==========================================
   // Port latches: byte lanes carry a port pair
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         out_q <= `RST_WORD;
      end
      else if (wrEn && avs_address == `OFS_OUT_LATCH)
      begin
         out_q <= beMerge(out_q, avs_writedata, avs_byteenable);
      end
      else if (wrEn && avs_address == `OFS_OUT_SET)
      begin
         // Set and clear views allow single-bit and nibble writes
         out_q <= out_q | beMerge(`RST_WORD, avs_writedata, avs_byteenable);
      end
      else if (wrEn && avs_address == `OFS_OUT_CLR)
      begin
         out_q <= out_q & ~beMerge(`RST_WORD, avs_writedata, avs_byteenable);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         dir_q <= `RST_WORD;
      end
      else if (wrEn && avs_address == `OFS_DIR)
      begin
         dir_q <= beMerge(dir_q, avs_writedata, avs_byteenable);
      end
   end

   // ==========================================
   // Configuration registers in byte lane 0
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         inPull_q  <= '0;
         pullGrp_q <= '0;
         odSel_q   <= '0;
         altEn_q   <= '0;
         edgeSel_q <= '0;
         toneCtl_q <= '0;
         mask_q    <= '0;
      end
      else if (wrEn && avs_byteenable[0])
      begin
         case (avs_address)
            `OFS_IN_PULL:  inPull_q  <= avs_writedata[3:0];
            `OFS_PULL_GRP: pullGrp_q <= avs_writedata[7:0];
            `OFS_OD_SEL:   odSel_q   <= avs_writedata[7:0];
            `OFS_ALT_EN:   altEn_q   <= avs_writedata[4:0];
            `OFS_EDGE_SEL: edgeSel_q <= avs_writedata[1:0];
            `OFS_TONE_CTL: toneCtl_q <= avs_writedata[2:0];
            `OFS_IRQ_MASK: mask_q    <= avs_writedata[4:0];
            default:       mask_q    <= mask_q;
         endcase
      end
   end

   // ==========================================
   // Pin drive: alternate outputs, open-drain, pull-ups
   always_comb
   begin
      drvVal = out_q;
      if (altEn_q[`ALT_TIMER0])
      begin
         drvVal[0] = timer0ClkPinSrc;
      end
      if (altEn_q[`ALT_TIMER1])
      begin
         drvVal[1] = timer1ClkPinSrc;
      end
      if (altEn_q[`ALT_DIVCLK])
      begin
         drvVal[2] = dividedSysclkPinSrc;
      end
      if (altEn_q[`ALT_TONE])
      begin
         drvVal[3] = toneOut;
      end
      if (altEn_q[`ALT_INTERVAL])
      begin
         drvVal[`INTERVAL_PIN] = intervalTimerClkPinSrc;
      end
   end

   always_comb
   begin
      odFull = `RST_WORD;
      odFull[`OD_LSB +: 8] = odSel_q;
      for (int i = 0; i < 32; i++)
      begin
         pullFull[i] = pullGrp_q[i / 4];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pinOut_q    <= `RST_WORD;
         pinOe_q     <= `RST_WORD;
         pinPull_q   <= `RST_WORD;
         inPullOut_q <= '0;
      end
      else
      begin
         // Open-drain bits only ever pull low; high is released
         pinOut_q    <= drvVal & ~odFull;
         pinOe_q     <= dir_q & ~(odFull & drvVal);
         pinPull_q   <= pullFull & ~dir_q;
         inPullOut_q <= inPull_q;
      end
   end

   // ==========================================
   // Edge events, sticky status, interrupt
   always_comb
   begin
      events = '0;
      events[`IRQ_EDGE_A] = edgeSel_q[0] ? inRise[0] : inFall[0];
      events[`IRQ_EDGE_B] = edgeSel_q[1] ? inRise[1] : inFall[1];
      events[`IRQ_RISE_Q] = inRise[2];
      events[`IRQ_BOTH]   = inRise[3] | inFall[3];
      events[`IRQ_KEY]    = |ioFall[`KEY_LSB +: 8];
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         status_q <= '0;
      end
      else if (wrEn && avs_byteenable[0] && avs_address == `OFS_IRQ_STAT)
      begin
         // A new event wins over a clear in the same cycle
         status_q <= (status_q & ~avs_writedata[4:0]) | events;
      end
      else
      begin
         status_q <= status_q | events;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(status_q & mask_q);
      end
   end

   assign avs_readdata    = rdData_q;
   assign avs_waitrequest = waitReq_q;
   assign ioPinOut        = pinOut_q;
   assign ioPinOe         = pinOe_q;
   assign ioPullUpEn      = pinPull_q;
   assign inputPullUpEn   = inPullOut_q;
   assign timer0ExtClkIn  = ioLevel[`TMR0_IN_BIT];
   assign timer1ExtClkIn  = ioLevel[`TMR1_IN_BIT];
   assign irq             = irq_q;

   // ==========================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_input_read: assert property (
      takeRead && avs_address == `OFS_IN_DATA |=> avs_readdata[3:0] == $past(inLevel))
      else $error("input port read mismatch");
   a_pull_off_out: assert property (
      (ioPullUpEn & $past(dir_q)) == 32'h0000_0000)
      else $error("pull-up on output pin");
   a_od_no_high: assert property (
      (ioPinOut[15:8] & $past(odSel_q)) == 8'h00)
      else $error("open-drain pin driven high");
   a_pair_write: assert property (
      wrEn && avs_address == `OFS_OUT_LATCH && avs_byteenable == 4'h2
      |=> out_q[15:8] == $past(avs_writedata[15:8]) && $stable(out_q[7:0]))
      else $error("pair write wrong");
   a_edge_sel: assert property (
      (edgeSel_q[0] ? inRise[0] : inFall[0]) |=> status_q[`IRQ_EDGE_A] ##1 irq || !mask_q[0])
      else $error("edge interrupt a missed");
   a_rise_quasi: assert property (
      inRise[2] |=> status_q[`IRQ_RISE_Q])
      else $error("rising quasi request missed");
   a_both_edge: assert property (
      inFall[3] |=> status_q[`IRQ_BOTH])
      else $error("falling edge of both-edge input missed");
   a_key_fall: assert property (
      |ioFall[23:16] |=> status_q[`IRQ_KEY])
      else $error("key scan request missed");
   a_reset_input: assert property (
      $past(sys_rst) |-> ioPinOe == 32'h0000_0000)
      else $error("pin driven after reset");
   a_alt_tone: assert property (
      $past(altEn_q[`ALT_TONE]) |-> ioPinOut[3] == $past(toneOut))
      else $error("tone pin not from alternate source");
   a_bus_answer: assert property (
      busState_q == BUS_WAIT && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");

   c_key_irq:   cover property (status_q[`IRQ_KEY] && irq);
   c_pair_wr:   cover property (wrEn && avs_address == `OFS_OUT_LATCH && avs_byteenable == 4'hF);
   c_tone_pin:  cover property (altEn_q[`ALT_TONE] && dir_q[3] && $rose(ioPinOut[3]));
endmodule

// ===== rtl/nibble_port_pkg.sv
package nibble_port_pkg;
   typedef logic [31:0] word_t;
   typedef logic [7:0]  addr_t;
   typedef logic [4:0]  irq_vec_t;
   typedef enum logic {BUS_WAIT, BUS_ACK} bus_state_t;
endpackage

// ===== rtl/pin_sync_edge.sv
`timescale 1ns/1ps
module pin_sync_edge #(
   parameter int WIDTH = 4
)(
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] pinRaw,
   output logic      [WIDTH-1:0] pinLevel,
   output logic      [WIDTH-1:0] pinRise,
   output logic      [WIDTH-1:0] pinFall
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] lvl_q;
   logic [WIDTH-1:0] prev_q;

   // ==========================================
   // Two-stage synchroniser plus history stage
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         lvl_q  <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= pinRaw;
         lvl_q  <= meta_q;
         prev_q <= lvl_q;
      end
   end

   assign pinLevel = lvl_q;
   assign pinRise  = lvl_q & ~prev_q;
   assign pinFall  = ~lvl_q & prev_q;
endmodule

// ===== rtl/tone_gen.sv
`timescale 1ns/1ps
module tone_gen #(
   parameter int HALF_16K = 6250
)(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       toneEn,
   input  wire logic [1:0] toneSel,
   output logic            toneOut
);
   localparam int CW = $clog2(HALF_16K * 8) + 1;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] limit;
   logic          tone_q;

   // ==========================================
   // Half period: sel 3 = 16 kHz down to sel 0 = 2 kHz
   assign limit = CW'(HALF_16K) << (2'd3 - toneSel);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !toneEn)
      begin
         cnt_q  <= '0;
         tone_q <= 1'b0;
      end
      else if (cnt_q >= limit - CW'(1))
      begin
         cnt_q  <= '0;
         tone_q <= ~tone_q;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   assign toneOut = tone_q;
endmodule

// ===== tb/nibble_port_pins_bench.sv
`timescale 1ns/1ps
`include "nibble_port_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module nibble_port_pins_bench;
   import nibble_port_pkg::*;
   logic        sys_clk = 0;
   logic        sys_rst = 1;
   addr_t       avs_address = '0;
   logic        avs_read = 0;
   logic        avs_write = 0;
   word_t       avs_writedata = '0;
   logic [3:0]  avs_byteenable = 4'h0;
   word_t       avs_readdata;
   logic        avs_waitrequest;
   logic [3:0]  inputOnlyPortBit;
   logic [3:0]  inputPullUpEn;
   logic [31:0] ioPinIn;
   logic [31:0] ioPinOut;
   logic [31:0] ioPinOe;
   logic [31:0] ioPullUpEn;
   logic        timer0ClkPinSrc = 0;
   logic        timer0ExtClkIn;
   logic        timer1ExtClkIn;
   logic        irq;
   logic [31:0] extVal = 32'hFFFF_FFFF;
   logic [31:0] extEn = 32'hFFFF_FFFF;
   logic [3:0]  inVal = 4'h0;
   logic [3:0]  inEn = 4'hF;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cycles = 0;
   word_t       rdat;
   int          half;
   initial forever #2.5 sys_clk = ~sys_clk;
   nibble_port_pins #(.TONE_HALF_16K(4)) i_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .inputOnlyPortBit(inputOnlyPortBit),
      .inputPullUpEn(inputPullUpEn), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe),
      .ioPullUpEn(ioPullUpEn), .timer0ClkPinSrc(timer0ClkPinSrc), .timer1ClkPinSrc(1'b0),
      .dividedSysclkPinSrc(1'b0), .intervalTimerClkPinSrc(1'b0), .timer0ExtClkIn(timer0ExtClkIn),
      .timer1ExtClkIn(timer1ExtClkIn), .irq(irq));
   nibble_port_pins_partner i_pins (
      .sys_clk(sys_clk), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe), .ioPullUpEn(ioPullUpEn),
      .inputPullUpEn(inputPullUpEn), .extVal(extVal), .extEn(extEn), .inVal(inVal), .inEn(inEn),
      .ioPinIn(ioPinIn), .inputOnlyPortBit(inputOnlyPortBit));
   // ==========================================
   // Closing and hang guard
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ==========================================
   // Avalon-MM master
   task automatic bus(input logic wr, input addr_t a, input word_t d, input logic [3:0] be, output word_t r);
      @(posedge sys_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= ~wr;
      // Hold the request until a rising edge samples waitrequest low
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic wr(input addr_t a, input word_t d, input logic [3:0] be = 4'hF);
      word_t r;
      bus(1'b1, a, d, be, r);
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic rd(input addr_t a, output word_t r);
      bus(1'b0, a, '0, 4'hF, r);
   endtask
   // Pins below 16 are the input-only port, others the io pins
   task automatic edgeStep(input int b, input logic v, input logic [4:0] e, input logic q);
      word_t r;
      @(posedge sys_clk);
      if (b < 16)
         inVal[b] <= v;
      else
         extVal[b] <= v;
      repeat (8) @(negedge sys_clk);
      rd(`OFS_IRQ_STAT, r);
      `CHK(r, {27'h0, e})
      `CHK(irq, q)
      wr(`OFS_IRQ_STAT, 32'h0000_001F);
   endtask
   task automatic tonePeriod(output int n);
      logic p;
      n = 0;
      p = ioPinOut[3];
      while (ioPinOut[3] === p && n < 300)
      begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      p = ioPinOut[3];
      while (ioPinOut[3] === p && n < 300)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   // ==========================================
   // Scenarios
   initial
   begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      `CHK(ioPinOe, 32'h0000_0000)
      `CHK(avs_waitrequest, 1'b1)
      repeat (4) @(negedge sys_clk);
      rd(`OFS_DIR, rdat);
      `CHK(rdat, 32'h0000_0000)
      wr(`OFS_DIR, 32'hFFFF_FFFF);
      wr(`OFS_OUT_LATCH, 32'h5A5A_5A5A);
      `CHK(ioPinOut, 32'h5A5A_5A5A)
      `CHK(ioPinOe, 32'hFFFF_FFFF)
      // Pin levels pass two synchroniser stages before they can be read
      repeat (4) @(negedge sys_clk);
      rd(`OFS_PIN_DATA, rdat);
      `CHK(rdat, 32'h5A5A_5A5A)
      // One lane moves the 4/5 pair only
      wr(`OFS_OUT_LATCH, 32'hA5A5_A5A5, 4'h2);
      `CHK(ioPinOut, 32'h5A5A_A55A)
      wr(`OFS_OUT_SET, 32'h0000_0001);
      wr(`OFS_OUT_CLR, 32'h0000_0002);
      `CHK(ioPinOut, 32'h5A5A_A559)
      wr(`OFS_DIR, 32'h0000_00F0);
      wr(`OFS_PULL_GRP, 32'h0000_00FF);
      `CHK(ioPullUpEn, 32'hFFFF_FF0F)
      wr(`OFS_DIR, 32'h0000_0100);
      wr(`OFS_OD_SEL, 32'h0000_0001);
      `CHK({ioPinOe[8], ioPinOut[8]}, 2'b00)
      wr(`OFS_OUT_CLR, 32'h0000_0100);
      `CHK({ioPinOe[8], ioPinOut[8]}, 2'b10)
      wr(`OFS_IN_PULL, 32'h0000_000A);
      `CHK(inputPullUpEn, 4'hA)
      @(posedge sys_clk);
      inVal <= 4'h5;
      repeat (6) @(negedge sys_clk);
      rd(`OFS_IN_DATA, rdat);
      `CHK(rdat, 32'h0000_0005)
      @(posedge sys_clk);
      inVal <= 4'h0;
      repeat (6) @(negedge sys_clk);
      wr(`OFS_IRQ_MASK, 32'h0000_001F);
      wr(`OFS_EDGE_SEL, 32'h0000_0001);
      wr(`OFS_IRQ_STAT, 32'h0000_001F);
      edgeStep(0, 1'b1, 5'h01, 1'b1);
      edgeStep(1, 1'b1, 5'h00, 1'b0);
      edgeStep(1, 1'b0, 5'h02, 1'b1);
      edgeStep(2, 1'b1, 5'h04, 1'b1);
      edgeStep(2, 1'b0, 5'h00, 1'b0);
      edgeStep(3, 1'b1, 5'h08, 1'b1);
      edgeStep(3, 1'b0, 5'h08, 1'b1);
      edgeStep(23, 1'b0, 5'h10, 1'b1);
      edgeStep(23, 1'b1, 5'h00, 1'b0);
      // Masked event stays in status without raising the line
      wr(`OFS_IRQ_MASK, 32'h0000_0000);
      edgeStep(0, 1'b0, 5'h00, 1'b0);
      edgeStep(0, 1'b1, 5'h01, 1'b0);
      wr(`OFS_DIR, 32'h0000_0019);
      wr(`OFS_ALT_EN, 32'h0000_0001);
      @(posedge sys_clk);
      timer0ClkPinSrc <= 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(ioPinOut[0], 1'b1)
      @(posedge sys_clk);
      timer0ClkPinSrc <= 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(ioPinOut[0], 1'b0)
      wr(`OFS_OUT_SET, 32'h0000_0010);
      repeat (4) @(negedge sys_clk);
      `CHK(timer0ExtClkIn, 1'b1)
      wr(`OFS_ALT_EN, 32'h0000_0008);
      for (int s = 3; s >= 0; s--)
      begin
         wr(`OFS_TONE_CTL, 32'h0000_0004 | s);
         tonePeriod(half);
         tonePeriod(half);
         `CHK(half, 4 << (3 - s))
      end
      rd(8'h3C, rdat);
      `CHK(rdat, 32'h0000_0000)
      tally_and_finish();
   end
endmodule

// ===== tb/nibble_port_pins_partner.sv
`timescale 1ns/1ps
// ==========================================
// External pins: keys, sources and pull-ups
module nibble_port_pins_partner (
   input  wire logic        sys_clk,
   input  wire logic [31:0] ioPinOut,
   input  wire logic [31:0] ioPinOe,
   input  wire logic [31:0] ioPullUpEn,
   input  wire logic [3:0]  inputPullUpEn,
   input  wire logic [31:0] extVal,
   input  wire logic [31:0] extEn,
   input  wire logic [3:0]  inVal,
   input  wire logic [3:0]  inEn,
   output logic      [31:0] ioPinIn,
   output logic      [3:0]  inputOnlyPortBit
);
   logic [31:0] ioFloat_q;
   logic [3:0]  inFloat_q;
   // A pin nobody drives or pulls shows a changing level, never a held one
   always_ff @(posedge sys_clk)
   begin
      ioFloat_q <= ~ioPinIn;
      inFloat_q <= ~inputOnlyPortBit;
   end
   assign ioPinIn = (ioPinOe & ioPinOut) | (~ioPinOe & extEn & extVal)
                  | (~ioPinOe & ~extEn & ioPullUpEn) | (~ioPinOe & ~extEn & ~ioPullUpEn & ioFloat_q);
   assign inputOnlyPortBit = (inEn & inVal) | (~inEn & inputPullUpEn) | (~inEn & ~inputPullUpEn & inFloat_q);
endmodule
